// *** include/lihs_defs.svh ***
// constants for the limit plus index homing sequencer
// assumes inclusion by bare name from the include folder
`ifndef LIHS_DEFS_SVH
`define LIHS_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define LIHS_OFS_CMD      12'h000
`define LIHS_OFS_TYPE     12'h004
`define LIHS_OFS_CFG      12'h008
`define LIHS_OFS_ACCEL    12'h00c
`define LIHS_OFS_DECEL    12'h010
`define LIHS_OFS_FAST     12'h014
`define LIHS_OFS_SLOW     12'h018
`define LIHS_OFS_STATUS   12'h01c
`define LIHS_OFS_POS      12'h020
`define LIHS_OFS_OFFSET   12'h024
`define LIHS_OFS_ERRCODE  12'h028
`define LIHS_OFS_ACYC     12'h02c

// ****************************************************************
// command and type codes
// ****************************************************************
`define LIHS_CMD_NORMAL   8'h10
`define LIHS_CMD_PROFILE  8'h17
`define LIHS_TYPE_HOME6   8'h36
`define LIHS_TYPE_LATCH_A 8'h12
`define LIHS_TYPE_LATCH_B 8'h13
`define LIHS_CERR_MODE    16'h0104
`define LIHS_CERR_NONE    16'h0000

// ****************************************************************
// config field positions
// ****************************************************************
`define LIHS_CFG_DIR      0
`define LIHS_CFG_ABS      1
`define LIHS_CFG_LATCH    2

// ****************************************************************
// status field positions
// ****************************************************************
`define LIHS_ST_COMPLETE  0
`define LIHS_ST_PROGRESS  1
`define LIHS_ST_CMDERR    2
`define LIHS_ST_HOMEFLT   3
`define LIHS_ST_STOREFLT  4
`define LIHS_ST_CMDFLT    5

// ****************************************************************
// timing
// ****************************************************************
`define LIHS_CLK_MHZ      100
`define LIHS_CYCLE_US     10
`define LIHS_CYCLE_CNT    (`LIHS_CYCLE_US * `LIHS_CLK_MHZ)
`define LIHS_NVM_TMO      16'h0400

`endif

// *** include/lihs_motion_if.sv ***
// velocity request and feedback between sequencer and profiler
// assumes one clock domain
interface lihs_motion_if;
  logic signed [31:0] target_vel;
  logic [15:0] accel;
  logic [15:0] decel;
  logic signed [31:0] vel;
  logic stopped;
  modport seq (output target_vel, output accel, output decel, input vel, input stopped);
  modport prof (input target_vel, input accel, input decel, output vel, output stopped);
endinterface

// *** include/lihs_pkg.sv ***
// types for the limit plus index homing sequencer
// assumes nothing beyond a SystemVerilog compiler
package lihs_pkg;
  typedef enum logic [2:0] {
    LIHS_IDLE = 3'b000,
    LIHS_AWAY = 3'b001,
    LIHS_STOP = 3'b011,
    LIHS_SLOW = 3'b010,
    LIHS_ZERO = 3'b110,
    LIHS_SAVE = 3'b111,
    LIHS_DONE = 3'b101,
    LIHS_FAIL = 3'b100
  } lihs_state_e;
  typedef logic signed [31:0] lihs_pos_t;
endpackage

// *** sim/lihs_axis_model.sv ***
// axis and memory model on the far side of the homing sequencer
// assumes the velocity command is in position units per clock cycle
module lihs_axis_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // scenario controls
  input wire logic ack_en,
  input wire logic both_lim,
  // device side
  input wire logic [31:0] vel_cmd_q,
  input wire logic nvm_write_q,
  output logic pos_limit,
  output logic neg_limit,
  output logic index_pulse,
  output logic nvm_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 3000;
  localparam int IW = 20;
  localparam int ACK_DLY = 30;
  int pos = 0;
  int ack_cnt = 0;
  // the axis keeps moving through a reset; reset does not teleport it
  always @(posedge pclk) begin
    pos <= pos + $signed(vel_cmd_q);
  end
  assign neg_limit = both_lim || (pos < -LIM);
  assign pos_limit = both_lim || (pos > LIM);
  // one index, much wider than the slow search step
  assign index_pulse = (pos >= 0) && (pos < IW);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_cnt <= 0;
      nvm_ack <= 1'b0;
    end else begin
      nvm_ack <= ack_en && (ack_cnt == 1);
      if (nvm_write_q) begin
        ack_cnt <= ACK_DLY;
      end else if (ack_cnt > 0) begin
        ack_cnt <= ack_cnt - 1;
      end
    end
  end
endmodule

// *** sim/limit_index_homing_sequencer_tb.sv ***
// self-checking bench for the homing sequencer
// assumes a 100 MHz clock and a four-cycle control tick
`include "lihs_defs.svh"
module limit_index_homing_sequencer_tb
  import lihs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, nvm_data_q, vel_cmd_q, rd, fast, slow;
  logic pos_limit, neg_limit, index_pulse, nvm_ack, nvm_write_q, ack_en, both_lim;
  logic homing_fault_q, offset_store_fault_q, command_fault_alarm_q;
  int mismatches, n_compared, vmin, vmax, vfirst, n_store, n;

  lihs_top #(.CYCLE_CNT(4)) lihs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_limit(pos_limit), .neg_limit(neg_limit),
    .index_pulse(index_pulse), .nvm_ack(nvm_ack), .nvm_write_q(nvm_write_q),
    .nvm_data_q(nvm_data_q), .vel_cmd_q(vel_cmd_q), .homing_fault_q(homing_fault_q),
    .offset_store_fault_q(offset_store_fault_q),
    .command_fault_alarm_q(command_fault_alarm_q));
  lihs_axis_model lihs_axis_model_i (.pclk(pclk), .presetn(presetn), .ack_en(ack_en),
    .both_lim(both_lim), .vel_cmd_q(vel_cmd_q), .nvm_write_q(nvm_write_q),
    .pos_limit(pos_limit), .neg_limit(neg_limit), .index_pulse(index_pulse),
    .nvm_ack(nvm_ack));

  // ****************************************************************
  // clock and motion monitor
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if ($signed(vel_cmd_q) < vmin) vmin = $signed(vel_cmd_q);
    if ($signed(vel_cmd_q) > vmax) vmax = $signed(vel_cmd_q);
    if (vfirst == 0) vfirst = $signed(vel_cmd_q);
    if (nvm_write_q === 1'b1) n_store++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic results;
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      chk("pready", 1, 0);
      results;
    end
  endtask
  task automatic wait_st(input int b);
    n = 0;
    do begin
      apb(1'b0, `LIHS_OFS_STATUS, 0);
      n++;
    end while (rd[b] !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      chk("status wait", 1, 0);
      results;
    end
  endtask
  task automatic home(input logic dir, input logic abs);
    fast = 30 + $urandom_range(10);
    slow = 1 + $urandom_range(3);
    apb(1'b1, `LIHS_OFS_CMD, 32'h10);
    apb(1'b1, `LIHS_OFS_TYPE, 32'h36);
    apb(1'b1, `LIHS_OFS_CFG, {30'h0, abs, dir});
    apb(1'b1, `LIHS_OFS_ACCEL, 4 + $urandom_range(4));
    apb(1'b1, `LIHS_OFS_DECEL, 4 + $urandom_range(4));
    apb(1'b1, `LIHS_OFS_FAST, fast);
    apb(1'b1, `LIHS_OFS_SLOW, slow);
    chk("vel before start", 0, vel_cmd_q);
    vmin = 0;
    vmax = 0;
    vfirst = 0;
    n_store = 0;
    apb(1'b1, `LIHS_OFS_CMD, 32'h17);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, both_lim} = '0;
    ack_en = 1'b1;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'hf5e4d969));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LIHS_OFS_STATUS, 0);
    chk("status reset", 0, rd);
    apb(1'b0, `LIHS_OFS_DECEL, 0);
    chk("decel reset", 1, rd);
    apb(1'b0, 12'h030, 0);
    chk("unmapped error", 1, {31'h0, err});
    // direction zero, incremental
    home(1'b0, 1'b0);
    apb(1'b0, `LIHS_OFS_STATUS, 0);
    chk("start status", 32'h2, rd & 32'h3f);
    apb(1'b0, `LIHS_OFS_CMD, 0);
    chk("cmd echo", 32'h17, rd);
    apb(1'b0, `LIHS_OFS_TYPE, 0);
    chk("type echo", 32'h36, rd);
    apb(1'b1, `LIHS_OFS_ACYC, $urandom);
    apb(1'b0, `LIHS_OFS_STATUS, 0);
    chk("progress after acyclic", 32'h2, rd & 32'h3);
    wait_st(`LIHS_ST_COMPLETE);
    chk("first move negative", 1, vfirst < 0);
    chk("fast speed", -fast, vmin);
    chk("slow speed", slow, vmax);
    chk("stopped", 0, vel_cmd_q);
    apb(1'b0, `LIHS_OFS_POS, 0);
    // index reads zero; the stop lands one control cycle of slow travel past it
    chk("position after stop", slow, rd);
    chk("no store", 0, n_store);
    // direction one, absolute
    home(1'b1, 1'b1);
    wait_st(`LIHS_ST_COMPLETE);
    chk("first move positive", 1, vfirst > 0);
    chk("fast speed up", fast, vmax);
    chk("slow speed down", -slow, vmin);
    chk("one store", 1, n_store);
    apb(1'b0, `LIHS_OFS_OFFSET, 0);
    chk("offset stored", rd, nvm_data_q);
    // store never acknowledged
    ack_en <= 1'b0;
    home(1'b0, 1'b1);
    wait_st(`LIHS_ST_STOREFLT);
    chk("store fault", 32'h10, rd & 32'h11);
    chk("store fault pin", 1, offset_store_fault_q);
    // both limits active
    ack_en <= 1'b1;
    both_lim <= 1'b1;
    home(1'b0, 1'b0);
    wait_st(`LIHS_ST_HOMEFLT);
    n = 0;
    while (vel_cmd_q !== 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("fault stops", 0, vel_cmd_q);
    chk("fault status", 32'h8, rd & 32'h9);
    chk("fault pin", 1, homing_fault_q);
    both_lim <= 1'b0;
    // type change while moving
    home(1'b0, 1'b0);
    apb(1'b1, `LIHS_OFS_TYPE, 32'h34);
    apb(1'b0, `LIHS_OFS_ERRCODE, 0);
    chk("error code", 32'h0104, rd);
    apb(1'b0, `LIHS_OFS_STATUS, 0);
    chk("alarm status", 32'h24, rd & 32'h24);
    chk("alarm pin", 1, command_fault_alarm_q);
    results;
  end
endmodule

// *** src/lihs_nvm_store.sv ***
// offset store to nonvolatile memory with completion timeout
// assumes nvm_ack pulses when the write ends
`include "lihs_defs.svh"
module lihs_nvm_store (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic nvm_ack,
  output logic busy,
  output logic done,
  output logic fail
);
  logic [15:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      cnt_q <= '0;
    end else begin
      done <= 1'b0;
      fail <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt_q <= '0;
      end else if (busy) begin
        cnt_q <= cnt_q + 16'h0001;
        if (nvm_ack) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (cnt_q == `LIHS_NVM_TMO) begin
          busy <= 1'b0;
          fail <= 1'b1;
        end
      end
    end
  end
endmodule

// *** src/lihs_profiler.sv ***
// linear ramp profiler: slews velocity toward target once per control cycle
// assumes tick is a one-clock pulse once per control cycle
module lihs_profiler
  import lihs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  // motion
  lihs_motion_if.prof m
);
  logic signed [31:0] vel_q;
  logic signed [32:0] diff;
  logic signed [32:0] rate;
  logic slowing;
  assign diff = 33'(m.target_vel) - 33'(vel_q);
  // shrinking speed in either direction follows the deceleration ramp
  assign slowing = (vel_q > 0 && diff < 0) || (vel_q < 0 && diff > 0);
  assign rate = slowing ? $signed({17'h0, m.decel}) : $signed({17'h0, m.accel});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_q <= '0;
    end else if (tick) begin
      if (diff > rate) begin
        vel_q <= vel_q + 32'(rate);
      end else if (-diff > rate) begin
        vel_q <= vel_q - 32'(rate);
      end else begin
        vel_q <= m.target_vel;
      end
    end
  end
  assign m.vel = vel_q;
  assign m.stopped = (vel_q == 0);
endmodule

// *** src/lihs_top.sv ***
// limit plus index homing sequencer with APB register file
// assumes limit, index and nvm inputs synchronous to pclk
//
// Summary of operation
// - direction zero: run negative, search positive
// - normal-to-profile edge starts fast reverse run
// - profile start clears homing complete
// - echo codes, in progress, no error
// - reverse limit hit: ramp down to stop
// - then slow search toward homing direction
// - stop at first index pulse
// - zero position or store absolute offset
// - homing complete raised at end
// - overtravel settings ignored, limit reverses
// - far limit or both limits: homing fault
// - other acyclic commands keep motion going
// - mode change in motion: command fault 0104
// - direction selectable either way
// - failed offset store raises store fault
//
// Design decisions made here: the register addresses and the APB slave port.
`include "lihs_defs.svh"
module lihs_top
  import lihs_pkg::*;
#(
  parameter int CYCLE_CNT = `LIHS_CYCLE_CNT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensors
  input wire logic pos_limit,
  input wire logic neg_limit,
  input wire logic index_pulse,
  // nonvolatile memory
  input wire logic nvm_ack,
  output logic nvm_write_q,
  output logic [31:0] nvm_data_q,
  // motion
  output logic [31:0] vel_cmd_q,
  output logic homing_fault_q,
  output logic offset_store_fault_q,
  output logic command_fault_alarm_q
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] cmd_q, type_q;
  logic [7:0] cmd_prev_q;
  logic homing_direction_select, abs_mode, latch_source_select;
  logic [15:0] accel_constant, decel_constant;
  logic [31:0] fast_search_speed, slow_search_speed;
  logic [15:0] cmd_err_q;
  logic [31:0] acyc_q;
  lihs_pos_t pos_q, absolute_origin_offset;
  lihs_state_e state_q;
  logic complete_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic wr, rd;
  logic store_busy, store_done, store_fail;
  logic signed [31:0] target_vel_d;
  logic [31:0] prdata_d;
  logic moving;
  lihs_motion_if mif ();

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign tick = (tick_cnt_q == 16'(CYCLE_CNT - 1));
  assign moving = (state_q != LIHS_IDLE) && (state_q != LIHS_DONE) && (state_q != LIHS_FAIL);

  // ****************************************************************
  // control cycle divider
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // apb writes
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 8'h00;
      type_q <= 8'h00;
      homing_direction_select <= 1'b0;
      abs_mode <= 1'b0;
      latch_source_select <= 1'b0;
      accel_constant <= 16'h0001;
      decel_constant <= 16'h0001;
      fast_search_speed <= '0;
      slow_search_speed <= '0;
      acyc_q <= '0;
    end else if (wr) begin
      if (hit(paddr, `LIHS_OFS_CMD)) cmd_q <= pwdata[7:0];
      if (hit(paddr, `LIHS_OFS_TYPE) && !moving) type_q <= pwdata[7:0];
      if (hit(paddr, `LIHS_OFS_CFG)) begin
        homing_direction_select <= pwdata[`LIHS_CFG_DIR];
        abs_mode <= pwdata[`LIHS_CFG_ABS];
        if (!(moving && (type_q == `LIHS_TYPE_LATCH_A || type_q == `LIHS_TYPE_LATCH_B))) begin
          latch_source_select <= pwdata[`LIHS_CFG_LATCH];
        end
      end
      if (hit(paddr, `LIHS_OFS_ACCEL)) accel_constant <= pwdata[15:0];
      if (hit(paddr, `LIHS_OFS_DECEL)) decel_constant <= pwdata[15:0];
      if (hit(paddr, `LIHS_OFS_FAST)) fast_search_speed <= pwdata;
      if (hit(paddr, `LIHS_OFS_SLOW)) slow_search_speed <= pwdata;
      // acyclic commands land here and do not touch motion
      if (hit(paddr, `LIHS_OFS_ACYC)) acyc_q <= pwdata;
    end
  end

  // ****************************************************************
  // command fault on mode change during motion
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_err_q <= `LIHS_CERR_NONE;
      command_fault_alarm_q <= 1'b0;
    end else if (wr && moving && ((hit(paddr, `LIHS_OFS_TYPE) && pwdata[7:0] != type_q) ||
                 (hit(paddr, `LIHS_OFS_CFG) && pwdata[`LIHS_CFG_LATCH] != latch_source_select &&
                  (type_q == `LIHS_TYPE_LATCH_A || type_q == `LIHS_TYPE_LATCH_B)))) begin
      cmd_err_q <= `LIHS_CERR_MODE;
      command_fault_alarm_q <= 1'b1;
    end else if (cmd_prev_q == `LIHS_CMD_NORMAL && cmd_q == `LIHS_CMD_PROFILE) begin
      cmd_err_q <= `LIHS_CERR_NONE;
    end
  end

  // ****************************************************************
  // homing sequence
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LIHS_IDLE;
      cmd_prev_q <= 8'h00;
      complete_q <= 1'b0;
      homing_fault_q <= 1'b0;
      offset_store_fault_q <= 1'b0;
      nvm_write_q <= 1'b0;
      nvm_data_q <= '0;
      absolute_origin_offset <= '0;
    end else begin
      cmd_prev_q <= cmd_q;
      nvm_write_q <= 1'b0;
      unique case (state_q)
        LIHS_IDLE, LIHS_DONE, LIHS_FAIL: begin
          // only the normal-to-profile edge starts motion
          if (cmd_prev_q == `LIHS_CMD_NORMAL && cmd_q == `LIHS_CMD_PROFILE &&
              type_q == `LIHS_TYPE_HOME6) begin
            complete_q <= 1'b0;
            homing_fault_q <= 1'b0;
            offset_store_fault_q <= 1'b0;
            state_q <= LIHS_AWAY;
          end
        end
        LIHS_AWAY: begin
          // overtravel settings have no say, limits steer the sequence
          if (pos_limit && neg_limit) begin
            homing_fault_q <= 1'b1;
            state_q <= LIHS_FAIL;
          end else if (homing_direction_select ? pos_limit : neg_limit) begin
            state_q <= LIHS_STOP;
          end
        end
        LIHS_STOP: begin
          if (pos_limit && neg_limit) begin
            homing_fault_q <= 1'b1;
            state_q <= LIHS_FAIL;
          end else if (mif.stopped) begin
            state_q <= LIHS_SLOW;
          end
        end
        LIHS_SLOW: begin
          if ((homing_direction_select ? neg_limit : pos_limit) || (pos_limit && neg_limit)) begin
            homing_fault_q <= 1'b1;
            state_q <= LIHS_FAIL;
          end else if (index_pulse && !neg_limit && !pos_limit) begin
            state_q <= LIHS_ZERO;
          end
        end
        LIHS_ZERO: begin
          if (mif.stopped) begin
            if (abs_mode) begin
              absolute_origin_offset <= pos_q;
              nvm_data_q <= pos_q;
              nvm_write_q <= 1'b1;
              state_q <= LIHS_SAVE;
            end else begin
              complete_q <= 1'b1;
              state_q <= LIHS_DONE;
            end
          end
        end
        LIHS_SAVE: begin
          if (store_done) begin
            complete_q <= 1'b1;
            state_q <= LIHS_DONE;
          end else if (store_fail) begin
            offset_store_fault_q <= 1'b1;
            state_q <= LIHS_FAIL;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // position counter
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= '0;
    end else if (state_q == LIHS_SLOW && index_pulse && !neg_limit && !pos_limit &&
                 !abs_mode) begin
      pos_q <= '0;
    end else if (tick) begin
      pos_q <= pos_q + mif.vel;
    end
  end

  // ****************************************************************
  // velocity target
  // ****************************************************************
  always_comb begin
    target_vel_d = '0;
    unique case (state_q)
      LIHS_AWAY: target_vel_d = homing_direction_select ? fast_search_speed : -fast_search_speed;
      LIHS_SLOW: target_vel_d = homing_direction_select ? -slow_search_speed : slow_search_speed;
      default: target_vel_d = '0;
    endcase
  end
  assign mif.target_vel = target_vel_d;
  assign mif.accel = accel_constant;
  assign mif.decel = decel_constant;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_cmd_q <= '0;
    end else begin
      vel_cmd_q <= mif.vel;
    end
  end

  lihs_profiler u_prof (.pclk(pclk), .presetn(presetn), .tick(tick), .m(mif));
  lihs_nvm_store u_nvm (
    .pclk(pclk), .presetn(presetn), .start(nvm_write_q), .nvm_ack(nvm_ack),
    .busy(store_busy), .done(store_done), .fail(store_fail)
  );

  // ****************************************************************
  // apb reads
  // ****************************************************************
  always_comb begin
    prdata_d = '0;
    if (hit(paddr, `LIHS_OFS_CMD)) prdata_d = {24'h0, cmd_q};
    if (hit(paddr, `LIHS_OFS_TYPE)) prdata_d = {24'h0, type_q};
    if (hit(paddr, `LIHS_OFS_CFG)) begin
      prdata_d = {29'h0, latch_source_select, abs_mode, homing_direction_select};
    end
    if (hit(paddr, `LIHS_OFS_ACCEL)) prdata_d = {16'h0, accel_constant};
    if (hit(paddr, `LIHS_OFS_DECEL)) prdata_d = {16'h0, decel_constant};
    if (hit(paddr, `LIHS_OFS_FAST)) prdata_d = fast_search_speed;
    if (hit(paddr, `LIHS_OFS_SLOW)) prdata_d = slow_search_speed;
    if (hit(paddr, `LIHS_OFS_STATUS)) begin
      prdata_d = {26'h0, command_fault_alarm_q, offset_store_fault_q, homing_fault_q,
                  cmd_err_q != `LIHS_CERR_NONE, moving, complete_q};
    end
    if (hit(paddr, `LIHS_OFS_POS)) prdata_d = pos_q;
    if (hit(paddr, `LIHS_OFS_OFFSET)) prdata_d = absolute_origin_offset;
    if (hit(paddr, `LIHS_OFS_ERRCODE)) prdata_d = {16'h0, cmd_err_q};
    if (hit(paddr, `LIHS_OFS_ACYC)) prdata_d = acyc_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `LIHS_OFS_ACYC || paddr[1:0] != 2'b00);
      if (rd) prdata <= prdata_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  start_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!moving && cmd_prev_q == `LIHS_CMD_NORMAL && cmd_q == `LIHS_CMD_PROFILE &&
     type_q == `LIHS_TYPE_HOME6) |=> !complete_q) else $error("start did not clear complete");
  start_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == LIHS_IDLE && cmd_prev_q == `LIHS_CMD_NORMAL && cmd_q == `LIHS_CMD_PROFILE &&
     type_q == `LIHS_TYPE_HOME6) |=> (state_q == LIHS_AWAY && !complete_q))
    else $error("profile edge did not start homing");
  no_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == LIHS_IDLE && cmd_q == `LIHS_CMD_NORMAL) |=> state_q == LIHS_IDLE)
    else $error("motion without profile command");
  limit_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == LIHS_AWAY && neg_limit && !pos_limit && !homing_direction_select)
    |=> state_q == LIHS_STOP) else $error("limit did not stop run");
  both_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (moving && state_q != LIHS_ZERO && state_q != LIHS_SAVE && pos_limit && neg_limit)
    |=> (homing_fault_q && state_q == LIHS_FAIL)) else $error("both limits no fault");
  fail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == LIHS_FAIL |-> !complete_q && target_vel_d == 0)
    else $error("failed homing reports complete");
  index_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == LIHS_SLOW && index_pulse && !neg_limit && !pos_limit) |=> state_q == LIHS_ZERO)
    else $error("index did not stop search");
  done_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == LIHS_DONE) |-> complete_q) else $error("done without complete flag");
  store_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == LIHS_SAVE && store_fail && !store_done) |=> offset_store_fault_q)
    else $error("store failure not flagged");
  mode_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && moving && hit(paddr, `LIHS_OFS_TYPE) && pwdata[7:0] != type_q)
    |=> (cmd_err_q == `LIHS_CERR_MODE && command_fault_alarm_q)) else $error("no mode error");
  home_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(complete_q));
  home_fail_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(homing_fault_q));
  store_run_c: cover property (@(posedge pclk) disable iff (!presetn) state_q == LIHS_SAVE);
endmodule
